// File: logic/bus_clock_divisor_map.vh
`ifndef BUS_CLOCK_DIVISOR_MAP_VH
`define BUS_CLOCK_DIVISOR_MAP_VH
// register offsets (byte addresses)
`define ADDR_DIV_CTRL 8'h00
`define ADDR_UNLOCK 8'h04
// field positions in the divisor control register
`define ON_BIT 15
`define RDY_BIT 11
`define DIV_MSB 6
`define DIV_LSB 0
`define DIV_W 7
// reset values
`define DIV_RESET 7'h01
`define DIV_RESET_BUS7 7'h00
`define RDATA_IDLE 32'h0000_0000
`define ON_RESET 1'b1
// unlock keys, written in order to the unlock register
`define KEY1 32'hA5A5_0F0F
`define KEY2 32'h5A5A_F0F0
`endif

// File: logic/clock_divisor_core.v
`timescale 1ns/10ps
`default_nettype none
// divides the system clock by (divisor + 1); the divisor input is compared live each cycle, not latched at a period boundary
module clock_divisor_core #(
  parameter W = 7
) (
  // clock and reset
  input wire i_clk,
  input wire i_rstn,
  // control
  input wire i_enable,
  input wire [W-1:0] i_divisor,
  // status and clock
  output reg o_boundary,
  output reg o_clk_en
);
  reg [W-1:0] cnt_r;
  reg [W-1:0] cnt_nxt;
  wire at_end;

  // period ends when the counter reaches the divisor
  assign at_end = (cnt_r >= i_divisor);

  always @* begin
    cnt_nxt = at_end ? {W{1'b0}} : cnt_r + {{(W-1){1'b0}}, 1'b1};
  end

  // clock enable pulse once per period; held low while disabled
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_r <= {W{1'b0}};
      o_boundary <= 1'b0;
      o_clk_en <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      o_boundary <= at_end;
      o_clk_en <= at_end & i_enable;
    end
  end
endmodule // clock_divisor_core
`default_nettype wire

// File: logic/peripheral_bus_clock_divider.v
`timescale 1ns/10ps
`default_nettype none
`include "bus_clock_divisor_map.vh"
// How it works
// - bit 15 on drives the bus output clock; off holds it stopped.
// - ready flag bit 11 reads one when idle; divisor writes accepted only then.
// - during a divisor change ready reads zero and divisor writes are ignored.
// - bus clock is system clock divided by divisor plus one.
// - buses 1 and 7 refuse writing zero to the enable bit.
// - bus 7 divisor is read-only, zero, so its enable pulses every cycle and its clock output stays high.
// - control writes need the unlock key sequence first, else rejected.
// - unimplemented bits read as zero.
module peripheral_bus_clock_divider #(
  parameter BUS_INDEX = 2
) (
  // clock and reset
  input wire i_clk,
  input wire i_rstn,
  // register port
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  // bus clock output
  output wire o_bus_clk_en,
  output reg o_bus_clk
);
  // buses whose clock may never stop, and the one bus with a fixed divisor
  localparam FIXED_ON = (BUS_INDEX == 1) || (BUS_INDEX == 7);
  localparam FIXED_DIV = (BUS_INDEX == 7);
  localparam DW = `DIV_W;
  // divisor after reset; bus 7 runs straight off the system clock
  localparam [DW-1:0] RESET_DIV = FIXED_DIV ? `DIV_RESET_BUS7 : `DIV_RESET;
  // unlock states
  localparam U_LOCKED = 2'b00;
  localparam U_KEY1 = 2'b01;
  localparam U_OPEN = 2'b10;

  // unlock sequence state
  reg [1:0] ulk_r;
  reg [1:0] ulk_nxt;
  // programmed control fields
  reg on_r;
  reg on_nxt;
  reg [DW-1:0] div_r;
  reg [DW-1:0] div_nxt;
  // divisor change tracking
  reg busy_r;
  reg busy_nxt;
  reg [DW-1:0] div_act_r;
  reg [DW-1:0] div_act_nxt;
  // output clock shaping
  reg [DW-1:0] ph_r;
  reg [DW-1:0] ph_nxt;
  reg bus_clk_nxt;
  // read path
  reg [31:0] ctrl_val;
  reg [31:0] rdata_nxt;
  // decoded strobes and write qualifiers
  wire ctrl_wr;
  wire ulk_wr;
  wire key1_hit;
  wire key2_hit;
  wire ctrl_open;
  wire on_wr_ok;
  wire div_differs;
  wire div_wr_ok;
  // counter status and clock shaping terms
  wire boundary;
  wire switch_now;
  wire div_is_zero;
  wire [DW:0] period_len;
  wire [DW:0] half_len;
  wire [DW:0] ph_inc;

  // address decode of the write strobe
  assign ctrl_wr = i_wr && (i_addr == `ADDR_DIV_CTRL);
  assign ulk_wr = i_wr && (i_addr == `ADDR_UNLOCK);
  assign key1_hit = ulk_wr && (i_wdata == `KEY1);
  assign key2_hit = ulk_wr && (i_wdata == `KEY2);

  // a control write counts only straight after a full unlock
  assign ctrl_open = ctrl_wr && (ulk_r == U_OPEN);
  // buses 1 and 7 must keep running, so a zero for the enable is dropped
  assign on_wr_ok = ctrl_open && (!FIXED_ON || i_wdata[`ON_BIT]);
  // rewriting the live divisor starts no change and keeps ready high
  assign div_differs = (i_wdata[`DIV_MSB:`DIV_LSB] != div_r);
  assign div_wr_ok = ctrl_open && !FIXED_DIV && !busy_r && div_differs;
  // a pending divisor goes live on the first period end of the old ratio
  assign switch_now = busy_r && boundary;

  // unlock sequence; any other write relocks, so one unlock grants one control write
  always @* begin
    ulk_nxt = ulk_r;
    case (ulk_r)
      U_LOCKED: begin
        if (key1_hit)
          ulk_nxt = U_KEY1;
      end
      U_KEY1: begin
        if (key2_hit)
          ulk_nxt = U_OPEN;
        else if (i_wr)
          ulk_nxt = U_LOCKED;
      end
      U_OPEN: begin
        if (i_wr)
          ulk_nxt = U_LOCKED;
      end
      default: begin
        ulk_nxt = U_LOCKED;
      end
    endcase
  end

  // enable bit; off stops both the clock and its enable pulse
  always @* begin
    on_nxt = on_r;
    if (on_wr_ok)
      on_nxt = i_wdata[`ON_BIT];
  end

  // divisor field and change flag; a new write cannot meet the clear, as it needs ready
  always @* begin
    div_nxt = div_r;
    busy_nxt = busy_r;
    if (switch_now)
      busy_nxt = 1'h0;
    if (div_wr_ok) begin
      div_nxt = i_wdata[`DIV_MSB:`DIV_LSB];
      busy_nxt = 1'h1;
    end
  end

  // divisor seen by the counter; swapping it only at a period end avoids a short pulse
  always @* begin
    div_act_nxt = div_act_r;
    if (switch_now)
      div_act_nxt = div_r;
  end

  // control state registers
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ulk_r <= U_LOCKED;
      on_r <= `ON_RESET;
      div_r <= RESET_DIV;
      busy_r <= 1'h0;
      div_act_r <= RESET_DIV;
    end else begin
      ulk_r <= ulk_nxt;
      on_r <= on_nxt;
      div_r <= div_nxt;
      busy_r <= busy_nxt;
      div_act_r <= div_act_nxt;
    end
  end

  // period counter and one-cycle enable pulse per bus clock period
  clock_divisor_core #(
    .W(DW)
  ) u_core (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_enable(on_r),
    .i_divisor(div_act_r),
    .o_boundary(boundary),
    .o_clk_en(o_bus_clk_en)
  );

  // one bit wider so a ratio of 128 does not wrap to zero
  assign period_len = {1'h0, div_act_r} + {{DW{1'h0}}, 1'h1};
  assign half_len = period_len >> 1;
  assign ph_inc = {1'h0, ph_r} + {{DW{1'h0}}, 1'h1};
  assign div_is_zero = (div_act_r == {DW{1'h0}});

  // rises at each period end, falls half way; odd ratios spend the spare cycle low
  // a ratio of one cannot toggle at the system rate, so the clock then stays high
  always @* begin
    ph_nxt = ph_r;
    bus_clk_nxt = o_bus_clk;
    if (!on_r) begin
      ph_nxt = {DW{1'h0}};
      bus_clk_nxt = 1'h0;
    end else if (boundary) begin
      ph_nxt = {DW{1'h0}};
      bus_clk_nxt = 1'h1;
    end else begin
      ph_nxt = ph_inc[DW-1:0];
      if (ph_inc >= half_len)
        bus_clk_nxt = div_is_zero;
    end
  end

  // bus clock registers
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ph_r <= {DW{1'h0}};
      o_bus_clk <= 1'h0;
    end else begin
      ph_r <= ph_nxt;
      o_bus_clk <= bus_clk_nxt;
    end
  end

  // read image built field by field; every bit not named stays zero
  always @* begin
    ctrl_val = `RDATA_IDLE;
    ctrl_val[`ON_BIT] = on_r;
    ctrl_val[`RDY_BIT] = ~busy_r;
    ctrl_val[`DIV_MSB:`DIV_LSB] = div_r;
  end

  // unlock register is write-only, so reads there and anywhere unmapped give zero
  always @* begin
    rdata_nxt = `RDATA_IDLE;
    if (i_rd && (i_addr == `ADDR_DIV_CTRL))
      rdata_nxt = ctrl_val;
  end

  // read data stands in the one cycle after the strobe only
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn)
      o_rdata <= `RDATA_IDLE;
    else
      o_rdata <= rdata_nxt;
  end
endmodule // peripheral_bus_clock_divider
`default_nettype wire

// File: verif/peripheral_bus_clock_divider_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "bus_clock_divisor_map.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
module peripheral_bus_clock_divider_bench;
  logic i_clk = 0, i_rstn = 0, i_wr = 0, i_rd = 0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0, r2, r7;
  wire [31:0] d2, d7;
  wire e2, c2;
  int error_cnt = 0, cmp_count = 0, c;
  // bus 7 shares the register port so every write hits both
  peripheral_bus_clock_divider uut (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(d2), .o_bus_clk_en(e2), .o_bus_clk(c2));
  peripheral_bus_clock_divider #(.BUS_INDEX(7)) uut7 (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(d7),
    .o_bus_clk_en(), .o_bus_clk());
  initial forever #2.5 i_clk = ~i_clk;
  task wr(input [7:0] a, input [31:0] d);
    @(posedge i_clk) {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_clk) i_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task rd(input [7:0] a);
    @(posedge i_clk) {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_clk) i_rd <= 1'b0;
    #1 r2 = d2;
    r7 = d7;
  endtask
  task uwr(input [31:0] d);
    wr(8'h04, `KEY1);
    wr(8'h04, `KEY2);
    wr(8'h00, d);
  endtask
  // waits lean on the watchdog for their bound
  task rdy;
    r2 = 0;
    while (r2[11] !== 1'b1) rd(8'h00);
  endtask
  task per(input int n);
    while (e2 !== 1'b1) @(posedge i_clk) #1;
    c = 0;
    do @(posedge i_clk) #1 c++; while (e2 !== 1'b1);
    `CHK(c, n)
    // the divided clock rises one cycle after the enable pulse
    @(posedge i_clk) #1;
    `CHK(c2, 1'b1)
  endtask
  task complete_run;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #60000;
    error_cnt++;
    complete_run;
  end
  initial begin
    repeat (3) @(posedge i_clk);
    i_rstn <= 1'b1;
    rd(8'h00);
    `CHK(r2, 32'h0000_8801)
    `CHK(r7, 32'h0000_8800)
    $display("reset done");
    wr(8'h00, 32'h0000_0005);
    rd(8'h04);
    `CHK(r2, 32'h0)
    rd(8'h00);
    `CHK(r2, 32'h0000_8801)
    $display("lock done");
    uwr(32'h0000_807F);
    rdy;
    per(128);
    uwr(32'h0000_8003);
    rd(8'h00);
    `CHK(r2[11], 1'b0)
    `CHK(r7, 32'h0000_8800)
    uwr(32'h0000_8005);
    rdy;
    `CHK(r2, 32'h0000_8803)
    per(4);
    $display("divisor done");
    uwr(32'h0000_0003);
    rd(8'h00);
    `CHK(r2, 32'h0000_0803)
    `CHK(r7, 32'h0000_8800)
    `CHK(c2, 1'b0)
    $display("enable done");
    complete_run;
  end
endmodule // peripheral_bus_clock_divider_bench
`default_nettype wire

// File: verif/peripheral_bus_clock_divider_checker.sv
`timescale 1ns/10ps
`default_nettype none
module peripheral_bus_clock_divider_checker #(parameter BUS_INDEX = 2) (
  // watched ports
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_addr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic o_bus_clk_en,
  input wire logic o_bus_clk
);
  // one clock domain
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // control read answer; bus 7 given three cycles to settle after reset
  sequence s_rd; $past(i_rd && i_addr == 8'h00); endsequence
  sequence s_off; s_rd ##0 !o_rdata[15]; endsequence
  sequence s_b7; BUS_INDEX == 7 && $past(i_rstn, 3); endsequence
  property p_rsv; (o_rdata & 32'hFFFF7780) == 32'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit");
  property p_idle; !$past(i_rd && i_addr == 8'h00) |-> o_rdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("stray data");
  property p_oclk; s_off |-> !o_bus_clk; endproperty
  a_oclk: assert property (p_oclk) else $error("clock when off");
  property p_oen; s_off |-> !o_bus_clk_en; endproperty
  a_oen: assert property (p_oen) else $error("pulse when off");
  property p_on; s_rd |-> (BUS_INDEX != 1 && BUS_INDEX != 7) || o_rdata[15]; endproperty
  a_on: assert property (p_on) else $error("bus stopped");
  property p_d7; s_rd |-> BUS_INDEX != 7 || o_rdata[11:0] == 12'h800; endproperty
  a_d7: assert property (p_d7) else $error("bus7 divisor");
  property p_c7; s_b7 |-> o_bus_clk; endproperty
  a_c7: assert property (p_c7) else $error("bus7 clock");
  property p_e7; s_b7 |-> o_bus_clk_en; endproperty
  a_e7: assert property (p_e7) else $error("bus7 rate");
endmodule // peripheral_bus_clock_divider_checker
bind peripheral_bus_clock_divider peripheral_bus_clock_divider_checker #(.BUS_INDEX(BUS_INDEX))
  chk (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_bus_clk_en(o_bus_clk_en), .o_bus_clk(o_bus_clk));
`default_nettype wire
